// [verilog/adcf_defs.svh]
// Constants of the converter status-flag block: offsets, fields, resets.
// Assumes a 32-bit APB slave that decodes eight address bits.
`ifndef ADCF_DEFS_SVH
`define ADCF_DEFS_SVH

// Structure limits
`define ADCF_MAX_CH      8
`define ADCF_MAX_RW      12
`define ADCF_CH_IW       3
`define ADCF_IRQ_W       4
`define ADCF_AW          8

// Register byte offsets
`define ADCF_OFF_CTRL    8'h00
`define ADCF_OFF_MODE    8'h04
`define ADCF_OFF_CHEN    8'h10
`define ADCF_OFF_CHDIS   8'h14
`define ADCF_OFF_CHSR    8'h18
`define ADCF_OFF_STATUS  8'h1C
`define ADCF_OFF_LAST    8'h20
`define ADCF_OFF_ISR     8'h28
`define ADCF_OFF_ICR     8'h2C
`define ADCF_OFF_IER     8'h30
`define ADCF_RES_HI      3'h2

// Field positions
`define ADCF_CTRL_START  0
`define ADCF_MODE_SLEEP  0
`define ADCF_ST_DONE_LSB 0
`define ADCF_ST_OVR_LSB  8
`define ADCF_ST_DVAL     16
`define ADCF_ST_GOVR     17
`define ADCF_LAST_CH_LSB 16
`define ADCF_IRQ_DVAL    0
`define ADCF_IRQ_OVR     1
`define ADCF_IRQ_GOVR    2
`define ADCF_IRQ_SLEEP   3

// Reset values
`define ADCF_CHEN_RST    8'h00
`define ADCF_IER_RST     4'h0

`endif

// [verilog/adcf_pkg.sv]
// Types shared by the converter status-flag block.
// Assumes the constants header is on the include path.
`include "adcf_defs.svh"

package adcf_pkg;

    typedef enum logic [1:0] {SLP_AWAKE, SLP_ARMED, SLP_ASLEEP} adcf_sleep_t;

    typedef struct packed {
        logic [`ADCF_MAX_CH-1:0] done;
        logic [`ADCF_MAX_CH-1:0] ovr;
        logic [`ADCF_MAX_CH-1:0] chen;
        logic                    dval;
        logic                    govr;
        logic                    mode_sleep;
        logic                    start;
        logic                    core_sleep;
        adcf_sleep_t             slp;
        logic [`ADCF_MAX_RW-1:0] last_data;
        logic [`ADCF_CH_IW-1:0]  last_chan;
        logic                    pready;
        logic                    pslverr;
        logic [31:0]             prdata;
    } adcf_state_t;

    typedef struct packed {
        logic [`ADCF_IRQ_W-1:0] stat;
        logic [`ADCF_IRQ_W-1:0] en;
        logic                   irq;
    } adcf_irq_state_t;

endpackage

// [verilog/adcf_res_mem.sv]
// Per-channel result store with a registered read port.
// Assumes one write and one read per cycle on the peripheral clock.
`timescale 1ns/1ns

module adcf_res_mem #(
    parameter int RW = 10,
    parameter int AW = 3
) (
    // Clock, reset, enable
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          pce,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [RW-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [RW-1:0] rdata
);
    logic [RW-1:0] mem [0:(1<<AW)-1];
    logic [RW-1:0] rdata_q;

    if (RW < 1 || AW < 1 || AW > 8) begin : g_bad
        $error("adcf_res_mem: unsupported RW or AW");
    end

    // Array itself needs no reset: flags say which words are valid
    always_ff @(posedge pclk) begin
        if (pce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Write-first bypass so a read never returns a word being replaced
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else if (pce) begin
            rdata_q <= (we && waddr == raddr) ? wdata : mem[raddr];
        end
    end

    assign rdata = rdata_q;
endmodule

// [verilog/adcf_irq.sv]
// Sticky interrupt status, enable mask and one level interrupt output.
// Assumes event pulses and register strobes on the same clock.
`timescale 1ns/1ns

module adcf_irq
    import adcf_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   pce,
    // Events and software access
    input  wire logic [`ADCF_IRQ_W-1:0] ev,
    input  wire logic                   clr_we,
    input  wire logic                   en_we,
    input  wire logic [`ADCF_IRQ_W-1:0] wval,
    // Results
    output logic      [`ADCF_IRQ_W-1:0] stat,
    output logic      [`ADCF_IRQ_W-1:0] en,
    output logic                        irq
);
    adcf_irq_state_t st_q;
    adcf_irq_state_t st_d;

    // Clear first, then set, so a coinciding event survives
    always_comb begin
        st_d = st_q;
        if (clr_we) begin
            st_d.stat = st_q.stat & ~wval;
        end
        st_d.stat = st_d.stat | ev;
        if (en_we) begin
            st_d.en = wval;
        end
        st_d.irq = |(st_d.stat & st_d.en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{stat: '0, en: `ADCF_IER_RST, irq: 1'b0};
        end else if (pce) begin
            st_q <= st_d;
        end
    end

    assign stat = st_q.stat;
    assign en   = st_q.en;
    assign irq  = st_q.irq;
endmodule

// [verilog/adcf_flags.sv]
// Converter status flags: done, overrun, data-ready, global overrun,
// channel enables, deferred sleep, APB register slave.
// Assumes conversion-end pulses arrive on pclk from the analog core.
//
// Contract
// - Data-ready clears only on a last-result read, never on channel reads.
// - Data-ready rises only when new data is really stored.
// - An enabled channel's end sets data-ready despite other reads or done.
// - End of conversion stores data and sets data-ready despite a same-cycle disable.
// - A status read beside an end still sets or clears global overrun.
// - End with done and data-ready active sets global overrun despite reads.
// - A disable beside such an end still raises both overrun flags.
// - Channel or last-result read clears that channel's done flag.
// - Status read clears channel overrun unless an end hits a channel whose done is set.
// - A channel read clears only its own done flag.
// - Sleep written while idle takes effect after the next conversion.
`timescale 1ns/1ns

module adcf_flags
    import adcf_pkg::*;
#(
    parameter int NCH = `ADCF_MAX_CH,
    parameter int RW  = 10
) (
    // Clock, reset, clock enable
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  pce,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`ADCF_AW-1:0]   paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Analog core
    input  wire logic                  eoc_valid,
    input  wire logic [`ADCF_CH_IW-1:0] eoc_chan,
    input  wire logic [RW-1:0]         eoc_data,
    output logic                       conv_start,
    output logic                       core_sleep,
    output logic      [NCH-1:0]        chan_en,
    // Interrupt
    output logic                       irq
);
    localparam logic [`ADCF_MAX_CH-1:0] CMASK =
        `ADCF_MAX_CH'((1 << NCH) - 1);

    if (NCH < 1 || NCH > `ADCF_MAX_CH || RW < 1 || RW > `ADCF_MAX_RW)
    begin : g_bad
        $error("adcf_flags: unsupported NCH or RW");
    end

    adcf_state_t st_q;
    adcf_state_t st_d;

    // Bus phase decode
    logic                     acc;
    logic                     cap;
    logic                     fin;
    logic                     rd_cap;
    logic                     wr_fin;
    logic [`ADCF_CH_IW-1:0]   cidx;
    logic                     is_res;
    logic [31:0]              rdat;
    logic                     err;

    // Access strobes
    logic                     rd_status;
    logic                     rd_last;
    logic                     rd_res;
    logic                     wr_ctrl;
    logic                     wr_mode;
    logic                     wr_chen;
    logic                     wr_chdis;
    logic                     wr_icr;
    logic                     wr_ier;

    // Flag events
    logic                     eoc_ok;
    logic                     store;
    logic [`ADCF_MAX_CH-1:0]  ch_oh;
    logic [`ADCF_MAX_CH-1:0]  set_done;
    logic [`ADCF_MAX_CH-1:0]  set_ovr;
    logic [`ADCF_MAX_CH-1:0]  clr_done;
    logic [`ADCF_MAX_CH-1:0]  keep_m;
    logic                     govr_set;
    logic                     slp_enter;
    logic [`ADCF_IRQ_W-1:0]   irq_ev;
    logic [`ADCF_IRQ_W-1:0]   irq_stat;
    logic [`ADCF_IRQ_W-1:0]   irq_en;
    logic [RW-1:0]            mem_rdata;

    // Answer one cycle after the first access cycle; read data come
    // from the result store, which needs that cycle anyway
    assign acc    = pce & psel & penable;
    assign cap    = acc & ~st_q.pready;
    assign fin    = acc & st_q.pready;
    assign rd_cap = cap & ~pwrite;
    assign wr_fin = fin & pwrite;
    assign cidx   = paddr[4:2];
    assign is_res = (paddr[7:5] == `ADCF_RES_HI) && (paddr[1:0] == 2'h0)
                    && (int'(cidx) < NCH);

    // Read side effects act at the edge the data are captured
    assign rd_status = rd_cap && paddr == `ADCF_OFF_STATUS;
    assign rd_last   = rd_cap && paddr == `ADCF_OFF_LAST;
    assign rd_res    = rd_cap && is_res;

    // Writes act at the edge the master sees the answer
    assign wr_ctrl  = wr_fin && paddr == `ADCF_OFF_CTRL;
    assign wr_mode  = wr_fin && paddr == `ADCF_OFF_MODE;
    assign wr_chen  = wr_fin && paddr == `ADCF_OFF_CHEN;
    assign wr_chdis = wr_fin && paddr == `ADCF_OFF_CHDIS;
    assign wr_icr   = wr_fin && paddr == `ADCF_OFF_ICR;
    assign wr_ier   = wr_fin && paddr == `ADCF_OFF_IER;

    // Storing is judged on the enable held before this edge, so a
    // disable written in the same cycle cannot drop the data
    assign eoc_ok   = pce & eoc_valid;
    assign store    = eoc_ok & st_q.chen[eoc_chan];
    assign ch_oh    = `ADCF_MAX_CH'(1) << eoc_chan;
    assign set_done = store ? ch_oh : '0;
    assign set_ovr  = set_done & st_q.done;
    assign govr_set = store & st_q.dval;

    // Clear masks name exactly the channel read, nothing else
    always_comb begin
        clr_done = '0;
        if (rd_res) begin
            clr_done = clr_done | (`ADCF_MAX_CH'(1) << cidx);
        end
        if (rd_last) begin
            clr_done = clr_done | (`ADCF_MAX_CH'(1) << st_q.last_chan);
        end
    end
    assign keep_m = st_q.done & ~clr_done;

    // Register read multiplexer; unmapped or unaligned gives an error
    always_comb begin
        rdat = '0;
        err  = 1'b0;
        case (paddr)
            `ADCF_OFF_CTRL, `ADCF_OFF_CHEN, `ADCF_OFF_CHDIS,
            `ADCF_OFF_ICR: begin
                rdat = '0;
            end
            `ADCF_OFF_MODE: begin
                rdat[`ADCF_MODE_SLEEP] = st_q.mode_sleep;
            end
            `ADCF_OFF_CHSR: begin
                rdat[`ADCF_MAX_CH-1:0] = st_q.chen;
            end
            `ADCF_OFF_STATUS: begin
                rdat[`ADCF_ST_DONE_LSB +: `ADCF_MAX_CH] = st_q.done;
                rdat[`ADCF_ST_OVR_LSB +: `ADCF_MAX_CH]  = st_q.ovr;
                rdat[`ADCF_ST_DVAL] = st_q.dval;
                rdat[`ADCF_ST_GOVR] = st_q.govr;
            end
            `ADCF_OFF_LAST: begin
                rdat[`ADCF_MAX_RW-1:0] = st_q.last_data;
                rdat[`ADCF_LAST_CH_LSB +: `ADCF_CH_IW] = st_q.last_chan;
            end
            `ADCF_OFF_ISR: begin
                rdat[`ADCF_IRQ_W-1:0] = irq_stat;
            end
            `ADCF_OFF_IER: begin
                rdat[`ADCF_IRQ_W-1:0] = irq_en;
            end
            default: begin
                if (is_res) begin
                    rdat = 32'(mem_rdata);
                end else begin
                    err = 1'b1;
                end
            end
        endcase
    end

    // Next state of the whole block
    always_comb begin
        st_d         = st_q;
        st_d.start   = 1'b0;
        st_d.pready  = cap;
        st_d.pslverr = cap & err;
        if (rd_cap) begin
            st_d.prdata = rdat;
        end

        // Every flag: clear term first, set term last, set wins
        st_d.done = keep_m | set_done;
        st_d.ovr  = (st_q.ovr & ~{`ADCF_MAX_CH{rd_status}})
                    | set_ovr;
        st_d.dval = (st_q.dval & ~rd_last) | store;
        st_d.govr = (st_q.govr & ~rd_status) | govr_set;
        if (store) begin
            st_d.last_data = `ADCF_MAX_RW'(eoc_data);
            st_d.last_chan = eoc_chan;
        end

        // Software controls
        if (wr_chen) begin
            st_d.chen = st_q.chen | (pwdata[`ADCF_MAX_CH-1:0] & CMASK);
        end
        if (wr_chdis) begin
            st_d.chen = st_q.chen & ~pwdata[`ADCF_MAX_CH-1:0];
        end
        if (wr_mode) begin
            st_d.mode_sleep = pwdata[`ADCF_MODE_SLEEP];
        end
        if (wr_ctrl) begin
            st_d.start = pwdata[`ADCF_CTRL_START];
        end

        // Sleep is armed by the mode bit but only entered at the end
        // of a conversion; a start while asleep wakes for one more
        case (st_q.slp)
            SLP_AWAKE: begin
                if (st_q.mode_sleep) begin
                    st_d.slp = SLP_ARMED;
                end
            end
            SLP_ARMED: begin
                if (!st_q.mode_sleep) begin
                    st_d.slp = SLP_AWAKE;
                end else if (eoc_ok) begin
                    st_d.slp = SLP_ASLEEP;
                end
            end
            SLP_ASLEEP: begin
                if (!st_q.mode_sleep) begin
                    st_d.slp = SLP_AWAKE;
                end else if (st_d.start) begin
                    st_d.slp = SLP_ARMED;
                end
            end
            default: begin
                st_d.slp = SLP_AWAKE;
            end
        endcase
        st_d.core_sleep = (st_d.slp == SLP_ASLEEP);
    end

    assign slp_enter = (st_q.slp != SLP_ASLEEP) && (st_d.slp == SLP_ASLEEP);

    // Interrupt events are the same pulses that set the flags
    always_comb begin
        irq_ev                 = '0;
        irq_ev[`ADCF_IRQ_DVAL]  = store;
        irq_ev[`ADCF_IRQ_OVR]   = |set_ovr;
        irq_ev[`ADCF_IRQ_GOVR]  = govr_set;
        irq_ev[`ADCF_IRQ_SLEEP] = slp_enter;
    end

    // Async reset to constants only; everything frozen while pce low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= '0;
            st_q.chen <= `ADCF_CHEN_RST;
            st_q.slp  <= SLP_AWAKE;
        end else if (pce) begin
            st_q <= st_d;
        end
    end

    adcf_res_mem #(
        .RW (RW),
        .AW (`ADCF_CH_IW)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .pce     (pce),
        .we      (store),
        .waddr   (eoc_chan),
        .wdata   (eoc_data),
        .raddr   (cidx),
        .rdata   (mem_rdata)
    );

    adcf_irq u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .pce     (pce),
        .ev      (irq_ev),
        .clr_we  (wr_icr),
        .en_we   (wr_ier),
        .wval    (pwdata[`ADCF_IRQ_W-1:0]),
        .stat    (irq_stat),
        .en      (irq_en),
        .irq     (irq)
    );

    // Outputs straight from state flops
    assign prdata     = st_q.prdata;
    assign pready     = st_q.pready;
    assign pslverr    = st_q.pslverr;
    assign conv_start = st_q.start;
    assign core_sleep = st_q.core_sleep;
    assign chan_en    = st_q.chen[NCH-1:0];

    // Checks on the flag behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    dval_keep_a:
    assert property (st_q.dval && !rd_last |=> st_q.dval)
        else $error("data-ready lost without a last-result read");

    dval_cause_a:
    assert property ($rose(st_q.dval) |-> $past(store))
        else $error("data-ready rose without stored data");

    dval_set_a:
    assert property (store |=> st_q.dval)
        else $error("stored conversion did not raise data-ready");

    store_last_a:
    assert property (store |=> st_q.last_chan == $past(eoc_chan)
                     && st_q.last_data == $past(`ADCF_MAX_RW'(eoc_data)))
        else $error("stored conversion not in last-result register");

    govr_set_a:
    assert property (store && st_q.dval |=> st_q.govr)
        else $error("global overrun not raised");

    govr_clr_a:
    assert property (rd_status && !govr_set |=> !st_q.govr)
        else $error("status read did not clear global overrun");

    ovr_clr_a:
    assert property (rd_status && set_ovr == '0 |=> st_q.ovr == '0)
        else $error("status read did not clear channel overrun");

    ovr_set_a:
    assert property (store && st_q.done[eoc_chan]
                     |=> st_q.ovr[$past(eoc_chan)])
        else $error("channel overrun not raised");

    done_clr_a:
    assert property (rd_res && !(store && eoc_chan == cidx)
                     |=> !st_q.done[$past(cidx)])
        else $error("channel read did not clear its done flag");

    done_keep_a:
    assert property (pce |=> (st_q.done & $past(keep_m)) == $past(keep_m))
        else $error("done flag of another channel cleared");

    done_set_a:
    assert property (store |=> st_q.done[$past(eoc_chan)])
        else $error("done set lost against a clear");

    sleep_late_a:
    assert property (!st_q.core_sleep && !eoc_ok |=> !st_q.core_sleep)
        else $error("sleep entered without a conversion end");

    read_clear_c: cover property (store && rd_last);
    status_eoc_c: cover property (store && rd_status && st_q.dval);
    sleep_enter_c: cover property (st_q.slp == SLP_ARMED && eoc_ok);
endmodule

// [verif/adcf_core_model.sv]
// Behavioural model of the analog conversion core.
// Assumes conversion-end pulses are taken on the pclk edge after they rise.
`timescale 1ns/1ns

module adcf_core_model #(
    parameter int RW  = 10,
    parameter int LAT = 4
) (
    // Clock
    input  wire logic          pclk,
    // Control from the block
    input  wire logic          conv_start,
    // Conversion results
    output logic               eoc_valid,
    output logic [2:0]         eoc_chan,
    output logic [RW-1:0]      eoc_data
);
    initial begin
        eoc_valid = 1'b0;
        eoc_chan  = 3'h0;
        eoc_data  = '0;
    end

    // One-cycle end pulse; lines show inverse data once released
    task automatic fire(input logic [2:0] ch, input logic [RW-1:0] d);
        @(posedge pclk);
        eoc_valid <= 1'b1;
        eoc_chan  <= ch;
        eoc_data  <= d;
        @(posedge pclk);
        eoc_valid <= 1'b0;
        eoc_chan  <= ~ch;
        eoc_data  <= ~d;
    endtask

    // A start pulse converts channel 0 after a fixed latency
    always begin
        @(posedge pclk iff conv_start === 1'b1);
        repeat (LAT - 1) @(posedge pclk);
        fire(3'h0, 10'h2A5);
    end
endmodule

// [verif/tb_top.sv]
// Self-checking bench of the converter status-flag block.
// Assumes APB answers with one wait state; the core model makes ends.
`timescale 1ns/1ns
`include "adcf_defs.svh"

module tb_top;
    localparam logic [7:0]  ST = `ADCF_OFF_STATUS;
    localparam logic [7:0]  LS = `ADCF_OFF_LAST;
    localparam logic [31:0] FM = 32'h0003_FFFF;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        pce      = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, eoc_valid, conv_start;
    logic        core_sleep, irq;
    logic [2:0]  eoc_chan;
    logic [9:0]  eoc_data;
    logic [7:0]  chan_en;
    int          bad_count       = 0;
    int          samples_checked = 0;

    adcf_flags adcf_flags_inst (.pclk(pclk), .presetn(presetn), .pce(pce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .eoc_valid(eoc_valid), .eoc_chan(eoc_chan),
        .eoc_data(eoc_data), .conv_start(conv_start),
        .core_sleep(core_sleep), .chan_en(chan_en), .irq(irq));
    adcf_core_model adcf_core_model_inst (.pclk(pclk),
        .conv_start(conv_start), .eoc_valid(eoc_valid),
        .eoc_chan(eoc_chan), .eoc_data(eoc_data));

    // Free-running 20 MHz clock
    initial begin
        forever #25 pclk = ~pclk;
    end

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                psel    <= 1'b0;
                penable <= 1'b0;
                return;
            end
        end
        bad_count++;
        complete_run();
    endtask

    // Read and compare under a mask
    task automatic rdm(string nm, logic [7:0] a, logic [31:0] m,
                       logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask

    // Transfer with a conversion end landing on its acting edge
    task automatic coinc(logic w, logic [7:0] a, logic [31:0] wd, int n,
                         logic [2:0] ch, logic [9:0] d);
        fork
            apb(w, a, wd);
            begin
                repeat (n) @(posedge pclk);
                adcf_core_model_inst.fire(ch, d);
            end
        join
    endtask

    function automatic logic [7:0] res(int ch);
        return 8'h40 + 8'(ch * 4);
    endfunction

    task automatic t_reset();
        chk("irq", {31'h0, irq}, 32'h0);
        chk("chan_en", {24'h0, chan_en}, 32'h0);
        rdm("status", ST, 32'hFFFF_FFFF, 32'h0);
        rdm("isr", `ADCF_OFF_ISR, 32'hF, 32'h0);
        rdm("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        $display("reset test done");
    endtask

    // Enable low across an end: the event is lost, nothing changes
    task automatic t_freeze();
        pce <= 1'b0;
        adcf_core_model_inst.fire(3'h2, 10'h055);
        pce <= 1'b1;
        rdm("status", ST, FM, 32'h0);
        rdm("last", LS, 32'hFFFF_FFFF, 32'h0001_0155);
        $display("clock enable test done");
    endtask

    task automatic t_dval();
        apb(1'b1, `ADCF_OFF_CHEN, 32'h07);
        rdm("chsr", `ADCF_OFF_CHSR, 32'hFF, 32'h07);
        adcf_core_model_inst.fire(3'h1, 10'h155);
        apb(1'b0, res(2), 32'h0);
        rdm("status", ST, FM, 32'h0001_0002);
        rdm("res1", res(1), 32'h3FF, 32'h155);
        rdm("status", ST, FM, 32'h0001_0000);
        rdm("last", LS, 32'hFFFF_FFFF, 32'h0001_0155);
        rdm("status", ST, FM, 32'h0);
        $display("data ready test done");
    endtask

    task automatic t_same();
        adcf_core_model_inst.fire(3'h0, 10'h0AA);
        coinc(1'b0, res(1), 32'h0, 1, 3'h0, 10'h0BB);
        rdm("status", ST, FM, 32'h0003_0101);
        rdm("status", ST, FM, 32'h0001_0001);
        rdm("last", LS, 32'hFFFF_FFFF, 32'h0000_00BB);
        $display("coinciding read test done");
    endtask

    task automatic t_status();
        adcf_core_model_inst.fire(3'h2, 10'h011);
        adcf_core_model_inst.fire(3'h2, 10'h012);
        apb(1'b0, res(2), 32'h0);
        coinc(1'b0, ST, 32'h0, 1, 3'h2, 10'h013);
        rdm("status", ST, FM, 32'h0003_0004);
        adcf_core_model_inst.fire(3'h1, 10'h021);
        rdm("last", LS, 32'hFFFF_FFFF, 32'h0001_0021);
        coinc(1'b0, ST, 32'h0, 1, 3'h2, 10'h014);
        rdm("status", ST, FM, 32'h0001_0404);
        apb(1'b0, LS, 32'h0);
        $display("status read test done");
    endtask

    task automatic t_dis();
        adcf_core_model_inst.fire(3'h0, 10'h031);
        coinc(1'b1, `ADCF_OFF_CHDIS, 32'h02, 2, 3'h0, 10'h032);
        // Enables change at the write edge; look once they have settled
        @(posedge pclk);
        chk("chan_en", {24'h0, chan_en}, 32'h05);
        rdm("status", ST, FM, 32'h0003_0101);
        rdm("last", LS, 32'hFFFF_FFFF, 32'h0000_0032);
        adcf_core_model_inst.fire(3'h0, 10'h033);
        coinc(1'b0, LS, 32'h0, 1, 3'h1, 10'h3FF);
        // Done and overrun bits of every channel are not judged
        rdm("status", ST, 32'h0003_0000, 32'h0);
        rdm("last", LS, 32'hFFFF_FFFF, 32'h0000_0033);
        $display("disable test done");
    endtask

    task automatic t_irq();
        apb(1'b1, `ADCF_OFF_ICR, 32'hF);
        apb(1'b1, `ADCF_OFF_IER, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        adcf_core_model_inst.fire(3'h0, 10'h044);
        rdm("isr", `ADCF_OFF_ISR, 32'h1, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, `ADCF_OFF_IER, 32'h0);
        rdm("ier", `ADCF_OFF_IER, 32'hF, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, `ADCF_OFF_IER, 32'h1);
        apb(1'b1, `ADCF_OFF_ICR, 32'h1);
        rdm("isr", `ADCF_OFF_ISR, 32'h1, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("interrupt test done");
    endtask

    task automatic t_sleep();
        int i;
        apb(1'b1, `ADCF_OFF_MODE, 32'h1);
        repeat (10) @(posedge pclk);
        chk("core_sleep", {31'h0, core_sleep}, 32'h0);
        apb(1'b1, `ADCF_OFF_CTRL, 32'h1);
        for (i = 0; i < 30 && core_sleep !== 1'b1; i++)
            @(posedge pclk);
        chk("core_sleep", {31'h0, core_sleep}, 32'h1);
        rdm("last", LS, 32'hFFFF_FFFF, 32'h0000_02A5);
        rdm("isr", `ADCF_OFF_ISR, 32'h8, 32'h8);
        $display("sleep test done");
    endtask

    // Reset, then the scenarios in order
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_dval();
        t_freeze();
        t_same();
        t_status();
        t_dis();
        t_irq();
        t_sleep();
        complete_run();
    end
endmodule
